/* design/fsd_defs.svh */
// Constants of the slave diagnosis framer: offsets, fields, reset values and timing.
`ifndef FSD_DEFS_SVH
`define FSD_DEFS_SVH

// ****************************************
// Timing
// ****************************************
`define FSD_CLK_HZ 200000000
`define FSD_LAMP_PERIOD_S 20
`define FSD_LAMP_OFF_US 100
`define FSD_SETTLE_CYC 4'd4

// ****************************************
// Register byte offsets (frame byte n sits at 4*n)
// ****************************************
`define FSD_OFF_FRAME0 8'h00
`define FSD_OFF_FRAME9 8'h24
`define FSD_OFF_CTRL 8'h28
`define FSD_OFF_MADDR 8'h2c
`define FSD_OFF_ISTAT 8'h30
`define FSD_OFF_IMASK 8'h34
`define FSD_OFF_CFGIDX 8'h38
`define FSD_OFF_CFGDAT 8'h3c

// ****************************************
// Fields and reset values
// ****************************************
`define FSD_ST2_REPARAM 0
`define FSD_ST2_STATIC 1
`define FSD_ST2_RSVD 2
`define FSD_ST2_DEACT 7
`define FSD_ST1_DIAG 3
`define FSD_CTRL_RST 16'h0100
`define FSD_MADDR_RST 8'hff
`define FSD_HDR 8'h05
`define FSD_IRQ_DUP 0
`define FSD_IRQ_TYPE 1
`define FSD_IRQ_LAMP 2
`define FSD_IRQ_SCAN 3
`define FSD_CFG_LAMP 4

`endif

/* design/fsd_diag.sv */
// Slave diagnosis framer: line checker, diagnostic frame and Wishbone registers.
//
// Contract
// R1 - Standard part fills frame bytes zero to five.
// R2 - Status two bit zero requests reparameterization.
// R3 - Status two bit one flags static diagnosis.
// R4 - Status two bit seven flags slave deactivated.
// R5 - Byte three master address, FF until set.
// R6 - Bytes four, five: identification, high first.
// R7 - Device-specific part spans bytes six to nine.
// R8 - Byte six header reads 05 hex.
// R9 - Byte seven: defective lamp as XY.
// R10 - Byte eight: duplicated address as XY.
// R11 - Byte nine: mismatched module as XY.
// R12 - Checker visits every line and address.
// R13 - Duplicates first; report only first found.
// R14 - Corrected duplicate: next one, or cleared.
// R15 - Type compared only where no duplicate.
// R16 - Lamp tested only where no other error.
// R17 - Lamp test at most every twenty seconds.
// R18 - XY: high nibble line, low nibble address.
// R19 - Report bytes refresh at each scan end (byte seven only at the end of a lamp scan).
`timescale 1ns/1ps
`default_nettype none
`include "fsd_defs.svh"

module fsd_diag #(
    parameter logic [31:0] LAMP_PERIOD_CYC = 32'(64'(`FSD_LAMP_PERIOD_S) * 64'(`FSD_CLK_HZ)),
    parameter logic [31:0] LAMP_OFF_CYC = 32'(`FSD_LAMP_OFF_US * (`FSD_CLK_HZ / 1000000)),
    parameter logic [15:0] MFR_ID = 16'h5a3c // Arbitrary neutral value.
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    input wire fsd_pkg::fsd_line_in_t line_i,
    output fsd_pkg::fsd_line_sel_t sel_o,
    output logic lamp_off_o
);

    // ****************************************
    // Declarations
    // ****************************************
    fsd_pkg::fsd_line_in_t line_s1;
    fsd_pkg::fsd_line_in_t line_s2;
    fsd_pkg::fsd_state_t state;
    logic [3:0] settle_cnt;
    logic [31:0] off_cnt;
    logic [31:0] lamp_tmr;
    logic lamp_due;
    logic lamp_scan;
    logic [4:0] cfg_mem [0:63];
    logic [5:0] cfg_idx;
    logic [15:0] ctrl;
    logic [7:0] maddr;
    logic [3:0] istat;
    logic [3:0] imask;
    logic [7:0] run_dup;
    logic [7:0] run_type;
    logic [7:0] run_lamp;
    logic [7:0] rep_dup;
    logic [7:0] rep_type;
    logic [7:0] rep_lamp;
    logic wb_req;
    logic wb_wr;
    logic scan_end;
    logic [4:0] cur_cfg;
    logic [7:0] cur_xy;

    // Report code of a position: lines count from one, so 00 never names a module.
    function automatic logic [7:0] xy_code(input fsd_pkg::fsd_line_sel_t s);
        xy_code = {1'b0, 3'({1'b0, s.line} + 3'd1), s.addr}; // R18
    endfunction

    // Frame byte n as the master receives it.
    function automatic logic [7:0] frame_byte(input logic [3:0] n);
        logic [7:0] st2;
        st2 = ctrl[15:8];
        st2[`FSD_ST2_RSVD] = 1'b1;
        case (n)
            4'd0: frame_byte = ctrl[7:0] | {4'h0, |{rep_dup, rep_type, rep_lamp}, 3'h0}; // R1
            4'd1: frame_byte = st2; // R2 R3 R4
            4'd2: frame_byte = 8'h00;
            4'd3: frame_byte = maddr; // R5
            4'd4: frame_byte = MFR_ID[15:8]; // R6
            4'd5: frame_byte = MFR_ID[7:0]; // R6
            4'd6: frame_byte = `FSD_HDR; // R7 R8
            4'd7: frame_byte = rep_lamp; // R9
            4'd8: frame_byte = rep_dup; // R10
            4'd9: frame_byte = rep_type; // R11
            default: frame_byte = 8'h00;
        endcase
    endfunction

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr = wb_req && wb_we_i;
    assign scan_end = (state == fsd_pkg::S_NEXT) && (&{sel_o.line, sel_o.addr});
    assign cur_cfg = cfg_mem[{sel_o.line, sel_o.addr}];
    assign cur_xy = xy_code(sel_o);

    // ****************************************
    // Pin synchronisers
    // ****************************************

    // Module answers come from another domain, so they pass two flops first.
    always_ff @(posedge clk_i) begin
        line_s1 <= line_i;
        line_s2 <= line_s1;
    end

    // ****************************************
    // Line scan
    // ****************************************

    // The walk covers all 64 positions whatever the configuration says.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= fsd_pkg::S_SETTLE;
            sel_o <= '0;
            settle_cnt <= 4'h0;
            off_cnt <= 32'h0;
            lamp_off_o <= 1'b0;
        end else begin
            case (state)
                fsd_pkg::S_SETTLE: begin
                    settle_cnt <= settle_cnt + 4'h1;
                    if (settle_cnt == `FSD_SETTLE_CYC) begin
                        settle_cnt <= 4'h0;
                        state <= fsd_pkg::S_SAMPLE;
                    end
                end
                fsd_pkg::S_SAMPLE: begin
                    // Lamp goes dark only for a clean position on a lamp scan.
                    if (!line_s2.dup && line_s2.hw_type == cur_cfg[3:0]
                            && cur_cfg[`FSD_CFG_LAMP] && lamp_scan) begin // R16 R17
                        lamp_off_o <= 1'b1;
                        off_cnt <= 32'h0;
                        state <= fsd_pkg::S_LAMP;
                    end else begin
                        state <= fsd_pkg::S_NEXT;
                    end
                end
                fsd_pkg::S_LAMP: begin
                    off_cnt <= off_cnt + 32'h1;
                    if (off_cnt == LAMP_OFF_CYC - 32'h1) begin
                        lamp_off_o <= 1'b0;
                        state <= fsd_pkg::S_NEXT;
                    end
                end
                fsd_pkg::S_NEXT: begin
                    {sel_o.line, sel_o.addr} <= {sel_o.line, sel_o.addr} + 6'h01; // R12
                    state <= fsd_pkg::S_SETTLE;
                end
                default: state <= fsd_pkg::S_SETTLE;
            endcase
        end
    end

    // Findings of the running scan; only the first of each kind is kept.
    always_ff @(posedge clk_i) begin
        if (rst_i || scan_end) begin
            run_dup <= 8'h00;
            run_type <= 8'h00;
            run_lamp <= 8'h00;
        end else if (state == fsd_pkg::S_SAMPLE) begin
            if (line_s2.dup) begin
                if (run_dup == 8'h00) begin
                    run_dup <= cur_xy; // R13
                end
            end else if (line_s2.hw_type != cur_cfg[3:0] && run_type == 8'h00) begin
                run_type <= cur_xy; // R15
            end
        end else if (state == fsd_pkg::S_LAMP && off_cnt == LAMP_OFF_CYC - 32'h1) begin
            if (!line_s2.lamp_ok && run_lamp == 8'h00) begin
                run_lamp <= cur_xy; // R16
            end
        end
    end

    // A fresh scan replaces the duplicate and type reports (the lamp report only after a lamp scan), so a fixed duplicate gives way.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rep_dup <= 8'h00;
            rep_type <= 8'h00;
            rep_lamp <= 8'h00;
        end else if (scan_end) begin
            rep_dup <= run_dup; // R14 R19
            rep_type <= run_type; // R19
            if (lamp_scan) begin
                rep_lamp <= run_lamp; // R19
            end
        end
    end

    // Lamp test pacing; the period is long so lamps never seem to blink.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lamp_tmr <= 32'h0;
            lamp_due <= 1'b0;
            lamp_scan <= 1'b0;
        end else begin
            if (!lamp_due) begin
                lamp_tmr <= lamp_tmr + 32'h1;
            end
            if (lamp_tmr == LAMP_PERIOD_CYC - 32'h1) begin
                lamp_due <= 1'b1; // R17
            end
            if (scan_end) begin
                lamp_scan <= lamp_due; // R17
                if (lamp_due) begin
                    lamp_due <= 1'b0;
                    lamp_tmr <= 32'h0;
                end
            end
        end
    end

    // ****************************************
    // Registers
    // ****************************************

    // Control bytes feed the status bytes; master address starts at FF.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= `FSD_CTRL_RST;
            maddr <= `FSD_MADDR_RST; // R5
            imask <= 4'h0;
            cfg_idx <= 6'h00;
        end else if (wb_wr) begin
            if (wb_adr_i == `FSD_OFF_CTRL) begin
                if (wb_sel_i[0]) begin
                    ctrl[7:0] <= wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    ctrl[15:8] <= wb_dat_i[15:8]; // R2 R3 R4
                end
            end
            if (wb_adr_i == `FSD_OFF_MADDR && wb_sel_i[0]) begin
                maddr <= wb_dat_i[7:0];
            end
            if (wb_adr_i == `FSD_OFF_IMASK && wb_sel_i[0]) begin
                imask <= wb_dat_i[3:0];
            end
            if (wb_adr_i == `FSD_OFF_CFGIDX && wb_sel_i[0]) begin
                cfg_idx <= wb_dat_i[5:0];
            end
        end
    end

    // Configuration table; not reset, so software loads it before trusting reports.
    always_ff @(posedge clk_i) begin
        if (wb_wr && wb_adr_i == `FSD_OFF_CFGDAT && wb_sel_i[0]) begin
            cfg_mem[cfg_idx] <= wb_dat_i[4:0];
        end
    end

    // Sticky events; a new event beats a write-one clear in the same cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            istat <= 4'h0;
        end else begin
            if (wb_wr && wb_adr_i == `FSD_OFF_ISTAT && wb_sel_i[0]) begin
                istat <= (istat & ~wb_dat_i[3:0]) | {scan_end,
                    scan_end && lamp_scan && run_lamp != 8'h00,
                    scan_end && run_type != 8'h00, scan_end && run_dup != 8'h00};
            end else begin
                istat <= istat | {scan_end, scan_end && lamp_scan && run_lamp != 8'h00,
                    scan_end && run_type != 8'h00, scan_end && run_dup != 8'h00};
            end
        end
    end

    // Interrupt level is registered from the gated status.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(istat & imask);
        end
    end

    // Single-wait slave: ack one cycle after the request, dropped the next.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i) begin
                if (wb_adr_i <= `FSD_OFF_FRAME9 && wb_adr_i[1:0] == 2'b00) begin
                    wb_dat_o <= {24'h0, frame_byte(wb_adr_i[5:2])};
                end else if (wb_adr_i == `FSD_OFF_CTRL) begin
                    wb_dat_o <= {16'h0, ctrl};
                end else if (wb_adr_i == `FSD_OFF_MADDR) begin
                    wb_dat_o <= {24'h0, maddr};
                end else if (wb_adr_i == `FSD_OFF_ISTAT) begin
                    wb_dat_o <= {28'h0, istat};
                end else if (wb_adr_i == `FSD_OFF_IMASK) begin
                    wb_dat_o <= {28'h0, imask};
                end else if (wb_adr_i == `FSD_OFF_CFGIDX) begin
                    wb_dat_o <= {26'h0, cfg_idx};
                end else if (wb_adr_i == `FSD_OFF_CFGDAT) begin
                    wb_dat_o <= {27'h0, cfg_mem[cfg_idx]};
                end else begin
                    wb_dat_o <= 32'h0;
                end
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_read(logic [7:0] a);
        wb_req && !wb_we_i && wb_adr_i == a;
    endsequence

    property p_hdr_read;
        s_read(8'h18) |=> wb_ack_o && wb_dat_o == 32'h0000_0005;
    endproperty
    a_hdr_read: assert property (p_hdr_read) else $error("header byte not 05"); // R8

    property p_id_read;
        s_read(8'h10) |=> wb_dat_o[7:0] == MFR_ID[15:8];
    endproperty
    a_id_read: assert property (p_id_read) else $error("id high byte wrong"); // R6

    property p_maddr_start;
        $past(rst_i) |-> maddr == 8'hff;
    endproperty
    a_maddr_start: assert property (p_maddr_start) else $error("master address not FF"); // R5

    sequence s_ctrl_wr;
        wb_wr && wb_adr_i == 8'h28 && wb_sel_i[1];
    endsequence

    property p_status2;
        s_ctrl_wr ##3 s_read(8'h04) |=> wb_dat_o[7:0] ==
            ($past(wb_dat_i[15:8], 4) | 8'h04);
    endproperty
    a_status2: assert property (p_status2) else $error("status two wrong"); // R2 R3 R4

    property p_first_dup;
        state == fsd_pkg::S_SAMPLE && run_dup != 8'h00 && !scan_end
            |=> $stable(run_dup);
    endproperty
    a_first_dup: assert property (p_first_dup) else $error("later duplicate replaced first"); // R13

    property p_dup_code;
        state == fsd_pkg::S_SAMPLE && line_s2.dup && run_dup == 8'h00
            |=> run_dup == {1'b0, 3'({1'b0, $past(sel_o.line)} + 3'd1), $past(sel_o.addr)};
    endproperty
    a_dup_code: assert property (p_dup_code) else $error("duplicate code wrong"); // R18

    property p_dup_blocks_type;
        state == fsd_pkg::S_SAMPLE && line_s2.dup |=> $stable(run_type);
    endproperty
    a_dup_blocks_type: assert property (p_dup_blocks_type) else $error("type checked on dup"); // R15

    property p_lamp_gate;
        $rose(lamp_off_o) |-> lamp_scan && !$past(line_s2.dup);
    endproperty
    a_lamp_gate: assert property (p_lamp_gate) else $error("lamp test not allowed"); // R16

    property p_lamp_pace;
        $rose(lamp_scan) |-> $past(lamp_due) && lamp_tmr == 32'h0;
    endproperty
    a_lamp_pace: assert property (p_lamp_pace) else $error("lamp scan too early"); // R17

    property p_report;
        scan_end |=> rep_dup == $past(run_dup) && rep_type == $past(run_type)
            ##1 run_dup == 8'h00 || state == fsd_pkg::S_SETTLE;
    endproperty
    a_report: assert property (p_report) else $error("report not refreshed"); // R19 R14

    property p_walk;
        state == fsd_pkg::S_NEXT |=> {sel_o.line, sel_o.addr} ==
            6'($past({sel_o.line, sel_o.addr}) + 6'h01);
    endproperty
    a_walk: assert property (p_walk) else $error("scan skipped a position"); // R12

endmodule
`default_nettype wire

/* design/fsd_pkg.sv */
// Types shared by the slave diagnosis framer.
package fsd_pkg;

    // Sampled answer of the module addressed on the selected line.
    typedef struct packed {
        logic dup;
        logic [3:0] hw_type;
        logic lamp_ok;
    } fsd_line_in_t;

    // Line selection driven out to the module interfaces.
    typedef struct packed {
        logic [1:0] line;
        logic [3:0] addr;
    } fsd_line_sel_t;

    typedef enum logic [1:0] {
        S_SETTLE = 2'b00,
        S_SAMPLE = 2'b01,
        S_LAMP = 2'b10,
        S_NEXT = 2'b11
    } fsd_state_t;

endpackage

/* dv/fieldbus_slave_diagnosis_tb_top.sv */
// Self-checking bench of the slave diagnosis framer with a module-line model.
`timescale 1ns/1ps
`default_nettype none
`include "fsd_defs.svh"

module fieldbus_slave_diagnosis_tb_top;
    // ****************************************
    // Signals and instances
    // ****************************************

    localparam int LP = 2000;
    localparam logic [15:0] MFR = 16'h3c96; // Arbitrary value, not a real maker code.
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, lamp_off_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    fsd_pkg::fsd_line_in_t line_i;
    fsd_pkg::fsd_line_sel_t sel_o;
    int n_fail = 0;
    int total_checks = 0;
    int cyc_cnt = 0;
    logic [15:0] seed = 16'h0008;
    logic [3:0] cfg_typ [64];
    logic cfg_lamp [64];
    logic [63:0] seen = 64'h0;
    int last_rise [64];
    logic lamp_q = 1'b0;

    // Short lamp period and lamp-off time keep each lamp scan within a few scans.
    fsd_diag #(.LAMP_PERIOD_CYC(32'd2000), .LAMP_OFF_CYC(32'd20), .MFR_ID(MFR)) fsd_diag_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .line_i(line_i),
        .sel_o(sel_o), .lamp_off_o(lamp_off_o));
    fsd_line_model fsd_line_model_inst (.sel_i(sel_o), .lamp_off_i(lamp_off_o), .line_o(line_i));

    // Free-running 200 MHz clock.
    always #2.5 clk_i = ~clk_i;

    // ****************************************
    // Helpers
    // ****************************************

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Classic single cycle: hold the request until ack is sampled high, then release.
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                      output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        check(32'(n < 50), 32'h1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] r;
        wb(1'b1, adr, dat, r);
    endtask

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] r;
        wb(1'b0, adr, 32'h0, r);
        check(r, exp);
    endtask

    // Report code: line counted from one in the high nibble, address in the low one.
    function automatic logic [7:0] code(input int p);
        return {1'b0, 3'(p / 16) + 3'd1, 4'(p % 16)};
    endfunction

    // Whether position p shows a fault of kind k (0 address, 1 type, 2 lamp).
    function automatic logic hit(input int k, input int p);
        logic dp, te;
        dp = fsd_line_model_inst.dup_tab[p];
        te = fsd_line_model_inst.typ_tab[p] != cfg_typ[p];
        case (k)
            0: return dp;
            1: return !dp && te;
            default: return !dp && !te && cfg_lamp[p] && fsd_line_model_inst.bad_tab[p];
        endcase
    endfunction

    function automatic logic [7:0] first(input int k);
        for (int p = 0; p < 64; p++) begin
            if (hit(k, p)) begin
                return code(p);
            end
        end
        return 8'h00;
    endfunction

    function automatic logic [7:0] rst_byte(input int n);
        case (n)
            1: return 8'h05;
            3: return `FSD_MADDR_RST;
            4: return MFR[15:8];
            5: return MFR[7:0];
            6: return `FSD_HDR;
            default: return 8'h00;
        endcase
    endfunction

    task automatic chk_reports();
        rd_chk(8'h1c, {24'h0, first(2)});
        rd_chk(8'h20, {24'h0, first(0)});
        rd_chk(8'h24, {24'h0, first(1)});
    endtask

    // Each scan end raises the unmasked scan bit; wait for it and clear it.
    task automatic wait_scans(input int n);
        repeat (n) begin
            @(posedge clk_i); // The level lags a clear by one cycle, so skip its stale high.
            for (int i = 0; i < 4000 && irq_o !== 1'b1; i++) begin
                @(posedge clk_i);
            end
            check(32'(irq_o), 32'h1);
            wr(`FSD_OFF_ISTAT, 32'h8);
        end
    endtask

    // ****************************************
    // Monitors
    // ****************************************

    // Watchdog: running past the ceiling counts as a mismatch and ends the run.
    always @(posedge clk_i) begin
        if (cyc_cnt > 40000) begin
            n_fail++;
            stop_test();
        end
    end

    // Cycle count, position coverage and lamp-test legality, judged at every edge.
    always @(posedge clk_i) begin
        int p;
        cyc_cnt++;
        p = int'({sel_o.line, sel_o.addr});
        if (rst_i === 1'b0) begin
            seen[p] <= 1'b1;
        end
        lamp_q <= lamp_off_o;
        if (lamp_off_o === 1'b1 && lamp_q !== 1'b1) begin
            check(32'(hit(0, p) || hit(1, p) || !cfg_lamp[p]), 32'h0);
            if (last_rise[p] >= 0) begin
                check(32'(cyc_cnt - last_rise[p] >= LP), 32'h1);
            end
            last_rise[p] = cyc_cnt;
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************

    initial begin
        logic [31:0] r;
        logic [7:0] s2 [4];
        int d1, t, l;
        s2 = '{8'h00, 8'h01, 8'h02, 8'h80};
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h3;
        wb_dat_i = 32'h0;
        for (int p = 0; p < 64; p++) begin
            last_rise[p] = -1;
            cfg_lamp[p] = 1'b0;
            cfg_typ[p] = 4'h0;
        end
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        // Whole frame after reset, then control reset value, a hole, master address and status two bits.
        for (int n = 0; n < 10; n++) begin
            rd_chk(8'(4 * n), {24'h0, rst_byte(n)});
        end
        rd_chk(`FSD_OFF_CTRL, 32'h0100);
        wr(8'h80, 32'hffff_ffff);
        rd_chk(8'h80, 32'h0);
        wr(`FSD_OFF_MADDR, 32'h03);
        rd_chk(8'h0c, 32'h03);
        for (int b = 0; b < 4; b++) begin
            wr(`FSD_OFF_CTRL, {16'h0, s2[b], 8'h00});
            rd_chk(8'h04, {24'h0, s2[b] | 8'h04});
        end
        // Random configuration mirrored by the connected modules.
        for (int p = 0; p < 64; p++) begin
            seed = lfsr(seed);
            cfg_typ[p] = seed[3:0];
            cfg_lamp[p] = seed[4];
            fsd_line_model_inst.typ_tab[p] = seed[3:0];
            wr(`FSD_OFF_CFGIDX, 32'(p));
            wr(`FSD_OFF_CFGDAT, {27'h0, seed[4:0]});
        end
        // Two duplicates (one at the last position), a hidden and a plain type error,
        // a bad lamp, and a bad lamp behind a type error.
        seed = lfsr(seed);
        d1 = 17 + int'(seed[3:0]);
        t = 33 + int'(seed[7:4]);
        l = int'(seed[11:8]);
        fsd_line_model_inst.dup_tab[d1] = 1'b1;
        fsd_line_model_inst.dup_tab[63] = 1'b1;
        fsd_line_model_inst.typ_tab[d1] = ~cfg_typ[d1];
        fsd_line_model_inst.typ_tab[t] = ~cfg_typ[t];
        fsd_line_model_inst.bad_tab[l] = 1'b1;
        fsd_line_model_inst.bad_tab[t] = 1'b1;
        cfg_lamp[l] = 1'b1;
        cfg_lamp[t] = 1'b1;
        for (int i = 0; i < 2; i++) begin
            wr(`FSD_OFF_CFGIDX, 32'(i == 0 ? l : t));
            wr(`FSD_OFF_CFGDAT, {28'h1, cfg_typ[i == 0 ? l : t]});
        end
        wr(`FSD_OFF_ISTAT, 32'hf);
        wr(`FSD_OFF_IMASK, 32'h0);
        // A masked event stays off the interrupt line until unmasked.
        r = 32'h0;
        for (int i = 0; i < 400 && r[3] !== 1'b1; i++) begin
            wb(1'b0, `FSD_OFF_ISTAT, 32'h0, r);
        end
        check(32'(irq_o), 32'h0);
        wr(`FSD_OFF_IMASK, 32'h8);
        @(posedge clk_i);
        check(32'(irq_o), 32'h1);
        wr(`FSD_OFF_ISTAT, 32'h8);
        // The lamp byte only refreshes on a lamp scan, so wait until one has ended.
        wait_scans(4);
        chk_reports();
        fsd_line_model_inst.dup_tab[d1] = 1'b0;
        wait_scans(2);
        chk_reports();
        fsd_line_model_inst.dup_tab[63] = 1'b0;
        wait_scans(5);
        chk_reports();
        rd_chk(8'h1c, {24'h0, code(l)});
        fsd_line_model_inst.bad_tab[l] = 1'b0;
        fsd_line_model_inst.typ_tab[t] = cfg_typ[t];
        wait_scans(5);
        chk_reports();
        check(32'(&seen), 32'h1);
        stop_test();
    end
endmodule

`default_nettype wire

/* dv/fsd_line_model.sv */
// Behavioural model of the module lines that answer the position scanner.
`timescale 1ns/1ps
`default_nettype none

module fsd_line_model (
    input wire fsd_pkg::fsd_line_sel_t sel_i,
    input wire logic lamp_off_i,
    output var fsd_pkg::fsd_line_in_t line_o
);
    // ****************************************
    // Module table
    // ****************************************

    // Per-position state of the connected modules; the bench edits it to inject faults.
    logic dup_tab [64];
    logic [3:0] typ_tab [64];
    logic bad_tab [64];

    // Everything starts healthy and unpopulated until the bench fills the table.
    initial begin
        for (int p = 0; p < 64; p++) begin
            dup_tab[p] = 1'b0;
            typ_tab[p] = 4'h0;
            bad_tab[p] = 1'b0;
        end
    end

    // The selected module answers at once; lamp current is only sensed while the lamp
    // is switched off, so a scanner that samples at the wrong moment sees a failure.
    always_comb begin
        line_o.dup = dup_tab[{sel_i.line, sel_i.addr}];
        line_o.hw_type = typ_tab[{sel_i.line, sel_i.addr}];
        line_o.lamp_ok = lamp_off_i && !bad_tab[{sel_i.line, sel_i.addr}];
    end
endmodule

`default_nettype wire
